/* File: inc/nav_cfg.svh */
`ifndef NAV_CFG_SVH
`define NAV_CFG_SVH

// ---------------------------------------------------------------------
// Widths of the data path
// ---------------------------------------------------------------------
`define NAV_WORD_BITS 32
`define NAV_HALF_BITS 16
`define NAV_OFS_BITS 8
`define NAV_SUM_BITS 15
`define NAV_PAGE_BITS 4
`define NAV_ADDR_BITS 20
`define NAV_SLOT_BITS 4
`define NAV_FIFO_DEPTH 2

// ---------------------------------------------------------------------
// Field positions of a received word
// ---------------------------------------------------------------------
`define NAV_UPPER_MSB 31
`define NAV_UPPER_LSB 16
`define NAV_LOWER_MSB 15

// ---------------------------------------------------------------------
// Reset values and offset table step
// ---------------------------------------------------------------------
`define NAV_BASE_RST 16'h0000
`define NAV_PAGE_RST 4'h0
`define NAV_HALF_RST 16'h0000
`define NAV_PROM_SHIFT 1

`endif

/* File: inc/nav_pkg.sv */
`include "nav_cfg.svh"

package nav_pkg;

  // -------------------------------------------------------------------
  // Transfer sequencer states
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_REQ   = 3'b001,
    ST_WR_LO = 3'b010,
    ST_WR_HI = 3'b011,
    ST_DONE  = 3'b100
  } xfer_state_type;

  // -------------------------------------------------------------------
  // Carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic data_p;
    logic data_n;
    logic sync_p;
    logic sync_n;
  } nav_rx_pins_type;

  typedef struct packed {
    logic wr;
    logic [`NAV_ADDR_BITS-1:0] addr;
    logic [`NAV_HALF_BITS-1:0] data;
  } mem_write_type;

endpackage : nav_pkg

/* File: core/nav_word_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module nav_word_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // -------------------------------------------------------------------
  // Flags
  // -------------------------------------------------------------------
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = store[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Storage write, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      store[wr_ptr] <= i_in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
    end
  end

  // Fill level
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= '0;
    end else if (i_ce) begin
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end

endmodule : nav_word_fifo

`default_nettype wire

/* File: core/nav_link_shift.sv */
`timescale 1ns/10ps
`default_nettype none

`include "nav_cfg.svh"

module nav_link_shift
  import nav_pkg::*;
(
  // Link clock and reset
  input wire logic i_nav_clk,
  input wire logic i_nrst,
  // Differential pins from the unit under test
  input wire nav_rx_pins_type i_rx,
  // Received words toward the system domain
  output logic [`NAV_WORD_BITS-1:0] o_rx_word,
  output logic o_rx_toggle,
  // Transmit words from the system domain
  input wire logic [`NAV_WORD_BITS-1:0] i_tx_word,
  input wire logic i_tx_toggle,
  output logic o_tx_taken,
  output logic o_tx_data
);
  logic data_bit;
  logic sync_bit;
  logic [`NAV_WORD_BITS-1:0] rx_shift;
  logic [`NAV_WORD_BITS-1:0] tx_shift;
  logic [1:0] tog_sync;

  // -------------------------------------------------------------------
  // Receive side
  // -------------------------------------------------------------------
  // Differential to single ended; pins already belong to the link clock
  assign data_bit = i_rx.data_p & ~i_rx.data_n;
  assign sync_bit = i_rx.sync_p & ~i_rx.sync_n;

  // Word completes on the sync edge itself: the clock may stop after it
  always_ff @(posedge i_nav_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_shift <= '0;
      o_rx_word <= '0;
      o_rx_toggle <= 1'b0;
    end else begin
      rx_shift <= {rx_shift[`NAV_WORD_BITS-2:0], data_bit};
      if (sync_bit) begin
        o_rx_word <= {rx_shift[`NAV_WORD_BITS-2:0], data_bit};
        o_rx_toggle <= ~o_rx_toggle;
      end
    end
  end

  // -------------------------------------------------------------------
  // Transmit side
  // -------------------------------------------------------------------
  // Request toggle from the system clock, two stages
  always_ff @(posedge i_nav_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tog_sync <= 2'b00;
    end else begin
      tog_sync <= {tog_sync[0], i_tx_toggle};
    end
  end

  // Load only at a word boundary so frames never tear
  always_ff @(posedge i_nav_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_shift <= '0;
      o_tx_taken <= 1'b0;
      o_tx_data <= 1'b0;
    end else begin
      o_tx_data <= tx_shift[`NAV_WORD_BITS-1];
      if (sync_bit && (tog_sync[1] != o_tx_taken)) begin
        tx_shift <= i_tx_word;
        o_tx_taken <= tog_sync[1];
      end else begin
        tx_shift <= {tx_shift[`NAV_WORD_BITS-2:0], 1'b0};
      end
    end
  end

endmodule : nav_link_shift

`default_nettype wire

/* File: core/nav_serial_test_channel.sv */
`timescale 1ns/10ps
`default_nettype none

`include "nav_cfg.svh"

module nav_serial_test_channel
  import nav_pkg::*;
#(
  parameter int SLOT_BITS = `NAV_SLOT_BITS,
  parameter int FIFO_DEPTH = `NAV_FIFO_DEPTH
) (
  // Clocks, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_nav_clk,
  // Navigation link pins
  input wire nav_rx_pins_type i_nav_rx,
  output logic o_nav_tx_data,
  // Bus controller handshake
  output logic o_bus_req,
  input wire logic i_bus_ack,
  input wire logic i_bus_en,
  // Memory write port
  output mem_write_type o_mem,
  output logic o_addr_oe_n,
  input wire logic i_mem_done,
  // Host access
  input wire logic [`NAV_HALF_BITS-1:0] i_bus_data,
  input wire logic i_base_load,
  input wire logic i_page_load,
  input wire logic i_tx_lower_load,
  input wire logic i_tx_upper_load,
  input wire logic i_tx_send,
  input wire logic i_base_rd,
  output logic [`NAV_HALF_BITS-1:0] o_host_rdata,
  output logic o_tx_busy,
  // Status
  output logic o_nav_irq,
  output logic o_rx_stall
);

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  xfer_state_type state;
  xfer_state_type next_state;
  logic [`NAV_WORD_BITS-1:0] rx_word;
  logic rx_toggle;
  logic [2:0] rx_sync;
  logic rx_event;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`NAV_WORD_BITS-1:0] fifo_head;
  logic pop;
  logic upper_word_enable;
  logic lower_word_enable;
  logic [`NAV_HALF_BITS-1:0] upper_latch;
  logic [`NAV_HALF_BITS-1:0] lower_latch;
  logic [`NAV_HALF_BITS-1:0] internal_bus;
  logic [`NAV_HALF_BITS-1:0] base_latch;
  logic [`NAV_PAGE_BITS-1:0] page_latch;
  logic [`NAV_OFS_BITS-1:0] offset_latch;
  logic [SLOT_BITS-1:0] slot;
  logic [`NAV_SUM_BITS-1:0] sum;
  logic [`NAV_SUM_BITS-1:0] sum_next_half;
  logic [`NAV_HALF_BITS-1:0] tx_lower;
  logic [`NAV_HALF_BITS-1:0] tx_upper;
  logic tx_toggle;
  logic next_tx_toggle;
  logic tx_taken;
  logic [1:0] taken_sync;
  logic granted;
  logic in_write_next;

  // Offset table, one entry per word slot of the navigation frame
  function automatic logic [`NAV_OFS_BITS-1:0] prom_offset(
    input logic [SLOT_BITS-1:0] s
  );
    prom_offset = `NAV_OFS_BITS'(s) << `NAV_PROM_SHIFT;
  endfunction : prom_offset

  // -------------------------------------------------------------------
  // Link domain
  // -------------------------------------------------------------------
  nav_link_shift u_link (
    .i_nav_clk(i_nav_clk),
    .i_nrst(i_nrst),
    .i_rx(i_nav_rx),
    .o_rx_word(rx_word),
    .o_rx_toggle(rx_toggle),
    .i_tx_word({tx_upper, tx_lower}),
    .i_tx_toggle(tx_toggle),
    .o_tx_taken(tx_taken),
    .o_tx_data(o_nav_tx_data)
  );

  // Word-ready toggle crossing; word is stable for a frame after it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_sync <= 3'b000;
      taken_sync <= 2'b00;
    end else if (i_ce) begin
      rx_sync <= {rx_sync[1:0], rx_toggle};
      taken_sync <= {taken_sync[0], tx_taken};
    end
  end

  assign rx_event = rx_sync[2] ^ rx_sync[1];

  // -------------------------------------------------------------------
  // Two-entry word buffer
  // -------------------------------------------------------------------
  nav_word_fifo #(
    .W(`NAV_WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_in_valid(rx_event),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rx_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_head)
  );

  // Serial source cannot stall, so a full buffer is flagged instead
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_stall <= 1'b0;
    end else if (i_ce) begin
      o_rx_stall <= !fifo_in_ready;
    end
  end

  // -------------------------------------------------------------------
  // Transfer sequencer
  // -------------------------------------------------------------------
  assign granted = i_bus_ack && i_bus_en;

  // Next state and word enables
  always_comb begin
    next_state = state;
    upper_word_enable = 1'b0;
    lower_word_enable = 1'b0;
    pop = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (fifo_out_valid) begin
          next_state = ST_REQ;
        end
      end
      ST_REQ: begin
        if (granted) begin
          next_state = ST_WR_LO;
          lower_word_enable = 1'b1;
        end
      end
      ST_WR_LO: begin
        if (i_mem_done) begin
          next_state = ST_WR_HI;
          upper_word_enable = 1'b1;
        end
      end
      ST_WR_HI: begin
        if (i_mem_done) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        pop = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // -------------------------------------------------------------------
  // Word latches and internal bus
  // -------------------------------------------------------------------
  // Head word split into its halves when a transfer starts
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      upper_latch <= `NAV_HALF_RST;
      lower_latch <= `NAV_HALF_RST;
    end else if (i_ce && state == ST_IDLE && fifo_out_valid) begin
      upper_latch <= {fifo_head[`NAV_UPPER_MSB],
                      fifo_head[`NAV_UPPER_MSB-1:`NAV_UPPER_LSB]};
      lower_latch <= fifo_head[`NAV_LOWER_MSB:0];
    end
  end

  // Only one half may own the internal bus at a time
  assign internal_bus = upper_word_enable ? upper_latch :
                        lower_word_enable ? lower_latch :
                        `NAV_HALF_RST;

  // -------------------------------------------------------------------
  // Address generation
  // -------------------------------------------------------------------
  // Host loads the base and page; slot counts words per frame
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      base_latch <= `NAV_BASE_RST;
      page_latch <= `NAV_PAGE_RST;
    end else if (i_ce) begin
      if (i_base_load) begin
        base_latch <= i_bus_data;
      end
      if (i_page_load) begin
        page_latch <= i_bus_data[`NAV_PAGE_BITS-1:0];
      end
    end
  end

  // Offset caught when the word is taken, slot moves on when done
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      offset_latch <= '0;
      slot <= '0;
    end else if (i_ce) begin
      if (state == ST_IDLE && fifo_out_valid) begin
        offset_latch <= prom_offset(slot);
      end
      if (pop) begin
        slot <= SLOT_BITS'(slot + 1'b1);
      end
    end
  end

  assign sum = `NAV_SUM_BITS'(base_latch[`NAV_SUM_BITS-1:0] +
                              `NAV_SUM_BITS'(offset_latch));
  assign sum_next_half = `NAV_SUM_BITS'(sum + 1'b1);
  assign in_write_next = (next_state == ST_WR_LO) ||
                         (next_state == ST_WR_HI);

  // -------------------------------------------------------------------
  // Memory write port
  // -------------------------------------------------------------------
  // Lower half first at the sum, upper half in the next word
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mem <= '0;
    end else if (i_ce) begin
      if (lower_word_enable) begin
        o_mem.addr <= {page_latch, sum, 1'b0};
        o_mem.data <= internal_bus;
        o_mem.wr <= 1'b1;
      end else if (upper_word_enable) begin
        o_mem.addr <= {page_latch, sum_next_half, 1'b0};
        o_mem.data <= internal_bus;
        o_mem.wr <= 1'b1;
      end else if (state == ST_WR_HI && i_mem_done) begin
        o_mem.wr <= 1'b0;
      end
    end
  end

  // Address drivers follow acknowledge, request follows the write
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr_oe_n <= 1'b1;
      o_bus_req <= 1'b0;
      o_nav_irq <= 1'b0;
    end else if (i_ce) begin
      o_addr_oe_n <= !(in_write_next && i_bus_ack);
      o_bus_req <= in_write_next || next_state == ST_REQ;
      o_nav_irq <= (state == ST_DONE);
    end
  end

  // -------------------------------------------------------------------
  // Host transmit path and readback
  // -------------------------------------------------------------------
  assign next_tx_toggle = (i_tx_send && !o_tx_busy) ? ~tx_toggle
                                                     : tx_toggle;

  // Latches hold still while the link side may be loading them
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_lower <= `NAV_HALF_RST;
      tx_upper <= `NAV_HALF_RST;
      tx_toggle <= 1'b0;
      o_tx_busy <= 1'b0;
    end else if (i_ce) begin
      if (i_tx_lower_load && !o_tx_busy) begin
        tx_lower <= i_bus_data;
      end
      if (i_tx_upper_load && !o_tx_busy) begin
        tx_upper <= i_bus_data;
      end
      tx_toggle <= next_tx_toggle;
      o_tx_busy <= next_tx_toggle ^ taken_sync[1];
    end
  end

  // Base readback through the buffer, zero when not selected
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_host_rdata <= `NAV_HALF_RST;
    end else if (i_ce) begin
      o_host_rdata <= i_base_rd ? base_latch : `NAV_HALF_RST;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  req_hold_a: assert property (
    (i_ce && state == ST_REQ && !granted) |=> o_bus_req)
    else $error("request dropped before grant");

  grant_gate_a: assert property (
    (i_ce && state == ST_REQ) ##1 (state == ST_WR_LO) |->
      $past(i_bus_ack) && $past(i_bus_en))
    else $error("write started without acknowledge and enable");

  addr_gate_a: assert property (
    $fell(o_addr_oe_n) |-> $past(i_bus_ack))
    else $error("address driven without acknowledge");

  lower_addr_a: assert property (
    (i_ce && lower_word_enable) |=>
      o_mem.addr == {$past(page_latch), $past(sum), 1'b0} && o_mem.wr)
    else $error("lower write address wrong");

  upper_data_a: assert property (
    (i_ce && upper_word_enable) |=>
      o_mem.data == $past(upper_latch) &&
      o_mem.addr[`NAV_SUM_BITS:1] == $past(sum_next_half))
    else $error("upper half data or address wrong");

  done_irq_a: assert property (
    (i_ce && state == ST_WR_HI && i_mem_done) ##1 i_ce |=>
      o_nav_irq ##1 !o_nav_irq)
    else $error("transfer done interrupt missing or too long");

  req_release_a: assert property (
    (i_ce && state == ST_DONE) |=> !o_bus_req)
    else $error("request held after write completed");

  base_load_a: assert property (
    (i_ce && i_base_load) |=> base_latch == $past(i_bus_data))
    else $error("base address not latched");

  readback_a: assert property (
    (i_ce && i_base_rd) |=> o_host_rdata == $past(base_latch))
    else $error("readback does not show base address");

endmodule : nav_serial_test_channel

`default_nettype wire

/* File: tb/bus_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Bus controller and memory as seen from the channel
// ----------------------------------------------------------------------
module bus_ctrl_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Channel side
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic i_slow,
  output logic o_ack,
  output logic o_en,
  output logic o_done
);
  int seed = 32'h01d5;
  int cnt;
  int lim;
  logic grant;

  // Grant after a random lag, held while requested, both lines together
  always @(posedge i_clk or negedge i_nrst) begin
    grant = i_req && (o_ack || ($random(seed) & 1));
    if (!i_nrst) begin
      o_ack <= 1'b0;
      o_en <= 1'b0;
    end else begin
      o_ack <= grant;
      o_en <= grant;
    end
  end

  // Each half finishes after a wait; slow mode lets the buffer fill up
  always @(posedge i_clk or negedge i_nrst) begin
    lim = i_slow ? 300 : 2 + ($random(seed) & 3);
    if (!i_nrst) begin
      o_done <= 1'b0;
      cnt = 0;
    end else if (i_wr && !o_done && cnt >= lim) begin
      o_done <= 1'b1;
      cnt = 0;
    end else begin
      o_done <= 1'b0;
      cnt = i_wr ? cnt + 1 : 0;
    end
  end
endmodule : bus_ctrl_model

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb
  import nav_pkg::*;
;
  // --------------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------------
  logic i_clk = 0, i_nrst = 0, nav_clk = 0, slow = 0, ce = 1;
  nav_rx_pins_type rx = '0;
  logic [15:0] bus_data = '0;
  logic [5:0] stb = '0;  // Base, page, tx low, tx high, send, read
  logic ack, en, done, req, oe_n, tx_data, busy, irq, stall;
  mem_write_type mem;
  logic [15:0] rdata, base;
  logic [3:0] page;
  logic [31:0] txw, sr;
  logic [35:0] exp_q[$];  // Expected {address, data} per half
  int errors = 0, samples_checked = 0, seed = 32'he04b, cyc = 0;
  int irqs = 0, words = 0, slot = 0;
  bit found = 0, stall_seen = 0;

  nav_serial_test_channel i_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_nav_clk(nav_clk),
    .i_nav_rx(rx), .o_nav_tx_data(tx_data), .o_bus_req(req),
    .i_bus_ack(ack), .i_bus_en(en), .o_mem(mem), .o_addr_oe_n(oe_n),
    .i_mem_done(done), .i_bus_data(bus_data), .i_base_load(stb[0]),
    .i_page_load(stb[1]), .i_tx_lower_load(stb[2]),
    .i_tx_upper_load(stb[3]), .i_tx_send(stb[4]), .i_base_rd(stb[5]),
    .o_host_rdata(rdata), .o_tx_busy(busy), .o_nav_irq(irq),
    .o_rx_stall(stall)
  );

  bus_ctrl_model i_ctrl (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_wr(mem.wr),
    .i_slow(slow), .o_ack(ack), .o_en(en), .o_done(done)
  );

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  initial forever #2.5 i_clk = ~i_clk;

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic give_verdict;
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Address: page on top, base plus slot offset as bits 1..15, even
  function automatic logic [35:0] half(input logic [31:0] w, input int s,
                                       input bit hi);
    logic [14:0] sum;
    sum = base[14:0] + 15'(s * 2) + 15'(hi);
    return {page, sum, 1'b0, hi ? w[31:16] : w[15:0]};
  endfunction : half

  // One frame, first bit is the MSB, sync on the last bit only
  task automatic frame(input logic [31:0] w, input bit kept);
    if (kept) begin
      exp_q.push_back(half(w, slot, 0));
      exp_q.push_back(half(w, slot, 1));
      slot = (slot + 1) % 16;
      words++;
    end
    for (int i = 31; i >= 0; i--) begin
      rx = {w[i], ~w[i], i == 0, i != 0};
      #6 nav_clk = 1;
      #6 nav_clk = 0;
    end
    // Released lines show the opposite of what they last carried
    rx = {~w[0], w[0], 2'b01};
  endtask : frame

  task automatic host(input int k, input logic [15:0] v);
    @(negedge i_clk);
    bus_data = v;
    stb[k] = 1;
    @(negedge i_clk);
    stb[k] = 0;
  endtask : host

  task automatic drain;
    for (int n = 0; n < 3000 && (exp_q.size() != 0 || req !== 0); n++)
      @(negedge i_clk);
    repeat (2) @(negedge i_clk);
    check(exp_q.size() == 0 && req === 1'b0, "words not written");
  endtask : drain

  // --------------------------------------------------------------------
  // Monitors
  // --------------------------------------------------------------------
  // Each finished half is compared with the next expected one
  always @(posedge i_clk) begin
    cyc++;
    if (stall === 1'b1)
      stall_seen = 1;
    if (irq === 1'b1)
      irqs++;
    if (mem.wr === 1'b1)
      check(req === 1 && oe_n === 0, "bus released in write");
    if (done === 1'b1 && mem.wr === 1'b1) begin
      if (exp_q.size() == 0)
        check(0, "unexpected memory write");
      else
        check({mem.addr, mem.data} === exp_q.pop_front(), "write data");
    end
    if (cyc == 40000) begin
      errors++;
      give_verdict();
    end
  end

  // Sliding window over the serial output, looking for the sent word
  always @(negedge nav_clk) begin
    sr = {sr[30:0], tx_data};
    if (sr === txw)
      found = 1;
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    fork
      repeat (3) begin
        #7 nav_clk = 1;
        #6 nav_clk = 0;
      end
    join_none
    repeat (8) @(negedge i_clk);
    i_nrst = 1;
    check(req === 0 && mem === '0 && oe_n === 1 && irq === 0 &&
          stall === 0 && rdata === 0, "reset state");
    base = 16'($random(seed)) & 16'h9fff;
    page = 4'($random(seed));
    host(0, base);
    host(1, {12'h000, page});
    host(5, 16'h0000);
    check(rdata === base, "base readback");
    @(negedge i_clk);
    check(rdata === 16'h0000, "readback held");
    // Frozen clock enable: a base load must not land
    ce = 0;
    host(0, ~base);
    ce = 1;
    host(5, 16'h0000);
    check(rdata === base, "base loaded while frozen");
    // Corner words first, pairs back to back, slot wraps past 16
    for (int i = 0; i < 18; i++) begin
      frame(i == 0 ? 32'hffff_ffff : i == 1 ? 32'h8000_0001 :
            32'($random(seed)), 1);
      if (i % 2 == 1)
        drain();
    end
    // Transmit path; a load while pending must be ignored
    txw = $random(seed);
    host(2, txw[15:0]);
    host(3, txw[31:16]);
    host(4, 16'h0000);
    @(negedge i_clk);
    check(busy === 1'b1, "transmit not pending");
    host(2, ~txw[15:0]);
    found = 0;
    repeat (3) frame($random(seed), 1);
    check(found && busy === 1'b0, "serial word not sent");
    drain();
    // Slow memory: buffer fills, third word is lost
    slow = 1;
    frame(32'h1234_5678, 1);
    frame(32'hfedc_ba98, 1);
    frame(32'h0f0f_0f0f, 0);
    check(stall_seen, "buffer never full");
    drain();
    slow = 0;
    check(stall === 1'b0, "buffer not emptied");
    check(irqs == words, "interrupt count");
    give_verdict();
  end
endmodule : tb

`default_nettype wire
